// [sprc_consts.vh]
// Constants of the stepper pause and reverse controller.
`ifndef SPRC_CONSTS_VH
`define SPRC_CONSTS_VH
// Motion command codes.
`define SPRC_CMD_IDLE 2'h0
`define SPRC_CMD_SCAN 2'h1
`define SPRC_CMD_FEED 2'h2
// Winding reference codes; 1 to 4 follow the microstep table.
`define SPRC_DAC_OFF 3'h0
`define SPRC_DAC_RUN 3'h2
`define SPRC_DAC_FULL 3'h4
`define SPRC_DAC_HOLD 3'h5
// Microsteps per full step, as a shift, and microstep index reset.
`define SPRC_MSTEP_SHIFT 2
`define SPRC_IDX_RST 4'h0
// Speed shifts of the profile segments.
`define SPRC_SHIFT_FULL 2'h0
`define SPRC_SHIFT_HALF 2'h1
`define SPRC_SHIFT_QTR 2'h2
`endif

// [sprc_motor.v]
// Stepper pause, reverse, acceleration and winding current logic.
`timescale 1ns/1ns
`include "sprc_consts.vh"
// What this block does
// - Zero reverse count: halt, finish current line.
// - Non-reversing: store 0 to 7 extra lines.
// - Non-reversing resume: after transfer plus offset, run.
// - Reverse count above zero selects reversing mode.
// - Reversing pause: finish line, record transfer-step offset.
// - Reversing resume: wait recorded offset before forward.
// - Three profile segments 0 to 3; zero skips.
// - Stop segment waits programmed step clocks.
// - Quarter speed: microstep lasts four step sizes.
// - Half speed: microstep lasts two step sizes.
// - Reversing pause follows the fixed segment order.
// - Paused: hold level in full step mode, then all phases off.
// - Reversing resume: resync, quarter, half, full forward.
// - Profile applies on start, and on stop, reverse and resume in reversing mode.
// - Reversing mode ignores process and discard counts.
// - Fast step size for feed and skip.
// - Full step current: kick, run, brake, hold, off.
// - PWM drivers so sensed current matches reference.
// - Four microsteps make one full step.
// - Fourteen bit step size, one microstep per period.
module sprc_motor #(
   parameter SW = 14,
   parameter PW = 8
) (
   input wire clock,
   input wire rstn,
   input wire pixel_tick,
   input wire line_transfer_pulse,
   input wire pause_req,
   input wire resume_req,
   input wire [1:0] motion_cmd,
   input wire skip_active,
   input wire full_step_mode,
   input wire [SW-1:0] scan_step_size,
   input wire [SW-1:0] fast_step_size,
   input wire [7:0] reverse_steps,
   input wire [1:0] accel_stop,
   input wire [1:0] accel_quarter,
   input wire [1:0] accel_half,
   input wire [2:0] lines_after_pause,
   input wire [2:0] lines_discard,
   input wire [2:0] kickstart_steps,
   input wire [4:0] hold_timeout,
   input wire [PW-1:0] pwm_period,
   input wire [PW-1:0] pwm_min_on,
   input wire sense_a_high,
   input wire sense_b_high,
   output reg phase_a,
   output reg phase_a_n,
   output reg phase_b,
   output reg phase_b_n,
   output reg [2:0] dac_a,
   output reg [2:0] dac_b,
   output reg motor_forward,
   output reg line_store_en,
   output reg paused
);
   // States of the motion sequencer.
   localparam S_IDLE = 4'h0, S_RUN = 4'h1, S_DHF = 4'h2, S_DQF = 4'h3;
   localparam S_STP = 4'h4, S_AQB = 4'h5, S_AHB = 4'h6, S_FB = 4'h7;
   localparam S_DHB = 4'h8, S_DQB = 4'h9, S_PAUSE = 4'ha, S_WTR = 4'hb;
   localparam S_WOF = 4'hc, S_AQF = 4'hd, S_AHF = 4'he;
   localparam TW = SW + 2;

   // ************************************************************
   // Reset release and pin synchronisers
   // ************************************************************
   reg [1:0] rst_q;
   wire rst_n_i = rst_q[1];
   reg [1:0] sense_a_q;
   reg [1:0] sense_b_q;

   // Reset is asserted at once and released two clocks later.
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end

   // Comparator pins come from the analog side, so two flops first.
   always @(posedge clock or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sense_a_q <= 2'h0;
         sense_b_q <= 2'h0;
      end else begin
         sense_a_q <= {sense_a_q[0], sense_a_high};
         sense_b_q <= {sense_b_q[0], sense_b_high};
      end
   end

   // ************************************************************
   // Segment helpers
   // ************************************************************
   // Speed of each segment as a shift of the base period.
   function [1:0] seg_shift;
      input [3:0] s;
      begin
         case (s)
            S_DQF, S_AQB, S_DQB, S_AQF: seg_shift = `SPRC_SHIFT_QTR;
            S_DHF, S_AHB, S_DHB, S_AHF: seg_shift = `SPRC_SHIFT_HALF;
            default: seg_shift = `SPRC_SHIFT_FULL;
         endcase
      end
   endfunction

   // Segment order of a reversing pause and of a restart.
   function [3:0] seg_next;
      input [3:0] s;
      begin
         case (s)
            S_DHF: seg_next = S_DQF;
            S_DQF: seg_next = S_STP;
            S_STP: seg_next = S_AQB;
            S_AQB: seg_next = S_AHB;
            S_AHB: seg_next = S_FB;
            S_FB: seg_next = S_DHB;
            S_DHB: seg_next = S_DQB;
            S_DQB: seg_next = S_PAUSE;
            S_AQF: seg_next = S_AHF;
            S_AHF: seg_next = S_RUN;
            default: seg_next = S_IDLE;
         endcase
      end
   endfunction

   // Length of a segment; stop counts step clocks, others full steps.
   function [7:0] seg_len;
      input [3:0] s;
      begin
         case (s)
            S_DHF, S_AHB, S_DHB, S_AHF: seg_len = {6'h00, accel_half};
            S_DQF, S_AQB, S_DQB, S_AQF: seg_len = {6'h00, accel_quarter};
            S_STP: seg_len = {6'h00, accel_stop};
            S_FB: seg_len = reverse_steps;
            default: seg_len = 8'h00;
         endcase
      end
   endfunction

   // Signed microstep table: bit 3 is the sign, bits 2:0 the level.
   function [3:0] sine_code;
      input [3:0] i;
      begin
         sine_code = {i[3], i[2] ? 3'h4 - {1'b0, i[1:0]} : {1'b0, i[1:0]}};
      end
   endfunction

   // ************************************************************
   // Motion sequencer
   // ************************************************************
   reg [3:0] state;
   reg [7:0] seg_left;
   reg [1:0] mcnt;
   reg [TW-1:0] tick_cnt;
   reg [3:0] idx;
   reg pend_pause;
   reg pend_resume;
   reg [15:0] pix_since_tr;
   reg [15:0] last_ofs;
   reg [15:0] wait_cnt;
   reg [2:0] line_cnt;
   reg draining;
   reg discarding;
   reg [2:0] kick_left;
   reg [7:0] hold_cnt;

   wire rev_mode = |reverse_steps;
   wire fast = (motion_cmd == `SPRC_CMD_FEED) || skip_active;
   wire [SW-1:0] base = fast ? fast_step_size : scan_step_size;
   wire [TW-1:0] period = {2'h0, base} << seg_shift(state);
   wire step_due = pixel_tick && (tick_cnt + 1'b1 >= period);
   wire moving = (state != S_IDLE) && (state != S_PAUSE) &&
                 (state != S_WTR) && (state != S_WOF);
   wire stepping = moving && (state != S_STP);
   wire [3:0] idx_step = motor_forward ? idx + 4'h1 : idx - 4'h1;

   // Pixel count since the last line transfer, for phase keeping.
   always @(posedge clock or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pix_since_tr <= 16'h0000;
      end else if (line_transfer_pulse) begin
         pix_since_tr <= 16'h0000;
      end else if (pixel_tick) begin
         pix_since_tr <= pix_since_tr + 16'h0001;
      end
   end

   // Sequencer: a pause request waits in its flag until a step boundary, a resume until the pause state.
   always @(posedge clock or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= S_IDLE;
         seg_left <= 8'h00;
         mcnt <= 2'h0;
         tick_cnt <= {TW{1'b0}};
         idx <= `SPRC_IDX_RST;
         motor_forward <= 1'b1;
         pend_pause <= 1'b0;
         pend_resume <= 1'b0;
         last_ofs <= 16'h0000;
         wait_cnt <= 16'h0000;
         kick_left <= 3'h0;
         hold_cnt <= 8'h00;
      end else begin
         // A new pulse beats the clear of the same cycle.
         if (pause_req) begin
            pend_pause <= 1'b1;
         end else if (state == S_RUN && step_due) begin
            pend_pause <= 1'b0;
         end
         if (resume_req) begin
            pend_resume <= 1'b1;
         end else if (state == S_PAUSE) begin
            pend_resume <= 1'b0;
         end
         if (pixel_tick) begin
            tick_cnt <= step_due ? {TW{1'b0}} : tick_cnt + 1'b1;
         end
         // Hold timer counts base microstep periods while stopped.
         if (moving) begin
            hold_cnt <= 8'h00;
         end else if (step_due && hold_cnt != 8'hff) begin
            hold_cnt <= hold_cnt + 8'h01;
         end
         if (stepping && step_due) begin
            idx <= idx_step;
            mcnt <= mcnt + 2'h1;
            if (mcnt == 2'h3 && kick_left != 3'h0) begin
               kick_left <= kick_left - 3'h1;
            end
         end
         if (motion_cmd == `SPRC_CMD_IDLE && state != S_IDLE) begin
            state <= S_IDLE;
         end else begin
            case (state)
               S_IDLE: begin
                  if (motion_cmd != `SPRC_CMD_IDLE) begin
                     motor_forward <= 1'b1;
                     kick_left <= kickstart_steps;
                     state <= S_AQF;
                     seg_left <= seg_len(S_AQF);
                     tick_cnt <= {TW{1'b0}};
                  end
               end
               S_RUN: begin
                  if (step_due) begin
                     last_ofs <= pix_since_tr;
                     if (pend_pause) begin
                        state <= rev_mode ? S_DHF : S_PAUSE;
                        seg_left <= seg_len(S_DHF);
                     end
                  end
               end
               S_PAUSE: begin
                  if (pend_resume) begin
                     state <= S_WTR;
                  end
               end
               S_WTR: begin
                  if (line_transfer_pulse) begin
                     state <= S_WOF;
                     wait_cnt <= 16'h0000;
                  end
               end
               S_WOF: begin
                  if (wait_cnt >= last_ofs) begin
                     motor_forward <= 1'b1;
                     kick_left <= kickstart_steps;
                     tick_cnt <= {TW{1'b0}};
                     state <= rev_mode ? S_AQF : S_RUN;
                     seg_left <= seg_len(S_AQF);
                  end else if (pixel_tick) begin
                     wait_cnt <= wait_cnt + 16'h0001;
                  end
               end
               default: begin
                  // Profile segment; an empty one is skipped at once.
                  if (seg_left == 8'h00) begin
                     state <= seg_next(state);
                     seg_left <= seg_len(seg_next(state));
                     tick_cnt <= {TW{1'b0}};
                     if (state == S_STP) begin
                        motor_forward <= 1'b0;
                     end
                  end else if (step_due && (state == S_STP || mcnt == 2'h3)) begin
                     seg_left <= seg_left - 8'h01;
                  end
               end
            endcase
         end
      end
   end

   // ************************************************************
   // Line storing after pause and discarding after resume
   // ************************************************************
   wire enter_pause = state == S_RUN && step_due && pend_pause;
   wire restart = state == S_WOF && wait_cnt >= last_ofs;

   // Lines are counted on transfer pulses; the line in flight ends at the next one.
   always @(posedge clock or negedge rst_n_i) begin
      if (!rst_n_i) begin
         line_store_en <= 1'b1;
         line_cnt <= 3'h0;
         draining <= 1'b0;
         discarding <= 1'b0;
      end else if (enter_pause) begin
         draining <= 1'b1;
         line_cnt <= rev_mode ? 3'h0 : lines_after_pause;
      end else if (restart) begin
         draining <= 1'b0;
         discarding <= !rev_mode && lines_discard != 3'h0;
         line_cnt <= lines_discard;
         line_store_en <= rev_mode || lines_discard == 3'h0;
      end else if (line_transfer_pulse && (draining || discarding)) begin
         if (line_cnt == 3'h0) begin
            line_store_en <= discarding;
            draining <= 1'b0;
            discarding <= 1'b0;
         end else begin
            line_cnt <= line_cnt - 3'h1;
            if (discarding && line_cnt == 3'h1) begin
               line_store_en <= 1'b1;
               discarding <= 1'b0;
            end
         end
      end
   end

   // ************************************************************
   // Winding current and PWM drive
   // ************************************************************
   reg [PW-1:0] pwm_cnt;
   reg pwm_on_a;
   reg pwm_on_b;
   wire stopped = (state == S_PAUSE) || (state == S_WTR) || (state == S_WOF);
   wire braking = stopped && hold_cnt == 8'h00;
   wire holding = stopped && hold_cnt <= {1'b0, hold_timeout, 2'h0} && hold_timeout != 5'h00;
   // An idle command cuts the drivers at the very next edge, with no hold.
   wire energized = (moving || braking || holding) && motion_cmd != `SPRC_CMD_IDLE;
   wire [3:0] cod_a = sine_code(idx + 4'h4);
   wire [3:0] cod_b = sine_code(idx);
   wire fs_a = !idx[3];
   wire fs_b = idx[3] ^ idx[2];
   reg [2:0] next_lvl;

   // Full step level: kick, run, brake, then hold.
   always @* begin
      if (braking || (moving && kick_left != 3'h0)) begin
         next_lvl = `SPRC_DAC_FULL;
      end else if (moving) begin
         next_lvl = `SPRC_DAC_RUN;
      end else begin
         next_lvl = `SPRC_DAC_HOLD;
      end
   end

   // Each driver turns on at period start and off once sensed current
   // exceeds the reference after the least on time.
   always @(posedge clock or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwm_cnt <= {PW{1'b0}};
         pwm_on_a <= 1'b0;
         pwm_on_b <= 1'b0;
      end else if (pwm_cnt >= pwm_period) begin
         pwm_cnt <= {PW{1'b0}};
         pwm_on_a <= 1'b1;
         pwm_on_b <= 1'b1;
      end else begin
         pwm_cnt <= pwm_cnt + 1'b1;
         if (pwm_cnt >= pwm_min_on && sense_a_q[1]) begin
            pwm_on_a <= 1'b0;
         end
         if (pwm_cnt >= pwm_min_on && sense_b_q[1]) begin
            pwm_on_b <= 1'b0;
         end
      end
   end

   // Phase outputs; microstep mode keeps the last table levels in hold.
   always @(posedge clock or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_a <= 1'b0;
         phase_a_n <= 1'b0;
         phase_b <= 1'b0;
         phase_b_n <= 1'b0;
         dac_a <= `SPRC_DAC_OFF;
         dac_b <= `SPRC_DAC_OFF;
         paused <= 1'b0;
      end else begin
         paused <= stopped;
         if (!energized) begin
            phase_a <= 1'b0;
            phase_a_n <= 1'b0;
            phase_b <= 1'b0;
            phase_b_n <= 1'b0;
            dac_a <= `SPRC_DAC_OFF;
            dac_b <= `SPRC_DAC_OFF;
         end else if (full_step_mode) begin
            phase_a <= pwm_on_a && fs_a;
            phase_a_n <= pwm_on_a && !fs_a;
            phase_b <= pwm_on_b && fs_b;
            phase_b_n <= pwm_on_b && !fs_b;
            dac_a <= next_lvl;
            dac_b <= next_lvl;
         end else begin
            phase_a <= pwm_on_a && !cod_a[3] && cod_a[2:0] != 3'h0;
            phase_a_n <= pwm_on_a && cod_a[3] && cod_a[2:0] != 3'h0;
            phase_b <= pwm_on_b && !cod_b[3] && cod_b[2:0] != 3'h0;
            phase_b_n <= pwm_on_b && cod_b[3] && cod_b[2:0] != 3'h0;
            dac_a <= cod_a[2:0];
            dac_b <= cod_b[2:0];
         end
      end
   end
endmodule

// [sprc_motor_asserts.sv]
// Checker of the stepper pause and reverse controller ports.
`timescale 1ns/1ns
module sprc_motor_asserts (
   input wire clock,
   input wire rstn,
   input wire pause_req,
   input wire resume_req,
   input wire line_transfer_pulse,
   input wire [1:0] motion_cmd,
   input wire [7:0] reverse_steps,
   input wire phase_a,
   input wire phase_a_n,
   input wire phase_b,
   input wire phase_b_n,
   input wire [2:0] dac_a,
   input wire [2:0] dac_b,
   input wire motor_forward,
   input wire line_store_en,
   input wire paused
);
   // ***********************
   // Request history
   // ***********************
   reg saw_pause;
   reg saw_resume;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // A pause or resume must have been asked for before the state may change.
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         saw_pause <= 1'b0;
         saw_resume <= 1'b0;
      end else begin
         saw_pause <= pause_req | (saw_pause & ~paused);
         saw_resume <= resume_req | (saw_resume & paused);
      end
   end
   a_idle_off: assert property (motion_cmd == 2'h0 |=> {phase_a, phase_a_n, phase_b, phase_b_n} == 4'h0)
      else $error("drivers left on while idle");
   a_drive_a: assert property (!(phase_a && phase_a_n))
      else $error("winding a driven both ways");
   a_drive_b: assert property (!(phase_b && phase_b_n))
      else $error("winding b driven both ways");
   a_dac_code: assert property (dac_a <= 3'h5 && dac_b <= 3'h5)
      else $error("reference code out of range");
   a_reverse_mode: assert property ($fell(motor_forward) |-> reverse_steps != 8'h00)
      else $error("reversed with zero reverse count");
   a_pause_dir: assert property ($rose(paused) |-> motor_forward == (reverse_steps == 8'h00))
      else $error("wrong direction when paused");
   a_pause_cause: assert property ($rose(paused) |-> saw_pause)
      else $error("paused without request");
   a_resume_cause: assert property ($fell(paused) && motion_cmd != 2'h0 |-> saw_resume)
      else $error("resumed without request");
   a_store_line: assert property ($fell(line_store_en) |-> $past(line_transfer_pulse) || paused)
      else $error("storage stopped off a line boundary");
   c_rev_pause: cover property ($rose(paused) && !motor_forward);
   c_resume: cover property (paused && resume_req);
   c_store_off: cover property ($fell(line_store_en));
endmodule
bind sprc_motor sprc_motor_asserts u_chk (.clock(clock), .rstn(rstn), .pause_req(pause_req),
   .resume_req(resume_req), .line_transfer_pulse(line_transfer_pulse), .motion_cmd(motion_cmd),
   .reverse_steps(reverse_steps), .phase_a(phase_a), .phase_a_n(phase_a_n), .phase_b(phase_b),
   .phase_b_n(phase_b_n), .dac_a(dac_a), .dac_b(dac_b), .motor_forward(motor_forward),
   .line_store_en(line_store_en), .paused(paused));

// [sprc_motor_tb.sv]
// Self-checking testbench of the stepper pause and reverse controller.
`timescale 1ns/1ns
`include "sprc_consts.vh"
module sprc_motor_tb;
   reg clock = 1'b0;
   reg rstn = 1'b0;
   reg pixel_tick = 1'b0;
   reg line_transfer_pulse = 1'b0;
   reg pause_req = 1'b0;
   reg resume_req = 1'b0;
   reg [1:0] motion_cmd = `SPRC_CMD_IDLE;
   reg skip_active = 1'b0;
   reg full_step_mode = 1'b0;
   reg [13:0] scan_step_size = 14'h0002;
   reg [13:0] fast_step_size = 14'h0003;
   reg [7:0] reverse_steps = 8'h00;
   reg [1:0] accel_stop = 2'h1;
   reg [1:0] accel_quarter = 2'h0;
   reg [1:0] accel_half = 2'h0;
   reg [2:0] lines_after_pause = 3'h2;
   reg [2:0] lines_discard = 3'h2;
   reg [2:0] kickstart_steps = 3'h1;
   reg [4:0] hold_timeout = 5'h01;
   reg [7:0] pwm_period = 8'h10;
   reg [7:0] pwm_min_on = 8'h02;
   reg [5:0] pix_cnt = 6'h00;
   wire sense_a_high;
   wire sense_b_high;
   wire phase_a;
   wire phase_a_n;
   wire phase_b;
   wire phase_b_n;
   wire [2:0] dac_a;
   wire [2:0] dac_b;
   wire motor_forward;
   wire line_store_en;
   wire paused;
   integer miscompares = 0;
   integer comparisons = 0;
   integer n;
   sprc_motor u_sprc_motor (.clock(clock), .rstn(rstn), .pixel_tick(pixel_tick),
      .line_transfer_pulse(line_transfer_pulse), .pause_req(pause_req), .resume_req(resume_req),
      .motion_cmd(motion_cmd), .skip_active(skip_active), .full_step_mode(full_step_mode),
      .scan_step_size(scan_step_size), .fast_step_size(fast_step_size), .reverse_steps(reverse_steps),
      .accel_stop(accel_stop), .accel_quarter(accel_quarter), .accel_half(accel_half),
      .lines_after_pause(lines_after_pause), .lines_discard(lines_discard), .kickstart_steps(kickstart_steps),
      .hold_timeout(hold_timeout), .pwm_period(pwm_period), .pwm_min_on(pwm_min_on),
      .sense_a_high(sense_a_high), .sense_b_high(sense_b_high), .phase_a(phase_a), .phase_a_n(phase_a_n),
      .phase_b(phase_b), .phase_b_n(phase_b_n), .dac_a(dac_a), .dac_b(dac_b),
      .motor_forward(motor_forward), .line_store_en(line_store_en), .paused(paused));
   sprc_winding_model u_sprc_winding_model (.clock(clock), .phase_a(phase_a), .phase_a_n(phase_a_n),
      .phase_b(phase_b), .phase_b_n(phase_b_n), .dac_a(dac_a), .dac_b(dac_b),
      .sense_a_high(sense_a_high), .sense_b_high(sense_b_high));
   // ***********************
   // Clock and sensor timing
   // ***********************
   always #4 clock = ~clock;
   // A pixel period is four clocks and a line is sixteen pixels, short enough for quick pauses.
   always @(posedge clock) begin
      pix_cnt <= pix_cnt + 6'h01;
      pixel_tick <= (pix_cnt[1:0] == 2'h3);
      line_transfer_pulse <= (pix_cnt == 6'h3f);
   end
   // ***********************
   // Tasks
   // ***********************
   task report_and_stop;
      begin
         $display("comparisons %0d miscompares %0d", comparisons, miscompares);
         if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
         end else begin
            $display("TB: FAIL");
         end
         $finish;
      end
   endtask
   task check_val(input string name, input [7:0] exp, input [7:0] got);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("Error %0s expected %0h seen %0h", name, exp, got);
         end
      end
   endtask
   function logic pick(input integer sel);
      pick = (sel == 0) ? paused : (sel == 1) ? motor_forward : line_store_en;
   endfunction
   // Waits for a status level and counts the line transfers passed meanwhile.
   task wait_sig(input integer sel, input logic lvl, input integer lim);
      integer k;
      begin
         n = 0;
         for (k = 0; k < lim && pick(sel) !== lvl; k = k + 1) begin
            @(posedge clock);
            n = n + line_transfer_pulse;
         end
      end
   endtask
   // Requests start just after a line transfer so line counts are unambiguous.
   task pulse(input integer sel);
      begin
         @(posedge clock);
         while (line_transfer_pulse !== 1'b1) @(posedge clock);
         if (sel == 0) pause_req <= 1'b1;
         else resume_req <= 1'b1;
         @(posedge clock);
         pause_req <= 1'b0;
         resume_req <= 1'b0;
      end
   endtask
   // Measures the clocks between two changes of the winding reference.
   task meas_step(input [7:0] exp);
      integer k;
      reg [2:0] d;
      begin
         repeat (200) @(posedge clock);
         d = dac_a;
         for (k = 0; k < 200 && dac_a === d; k = k + 1) @(posedge clock);
         d = dac_a;
         for (k = 0; k < 200 && dac_a === d; k = k + 1) @(posedge clock);
         check_val("step clocks", exp, 8'(k));
      end
   endtask
   // ***********************
   // Test sequence
   // ***********************
   initial begin
      repeat (3) @(posedge clock);
      #1;
      check_val("reset outputs", 8'h06, {1'b0, phase_a, phase_a_n, phase_b, phase_b_n, motor_forward,
         line_store_en, paused});
      @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      motion_cmd <= `SPRC_CMD_FEED;
      meas_step(8'h0c);
      motion_cmd <= `SPRC_CMD_SCAN;
      meas_step(8'h08);
      skip_active <= 1'b1;
      meas_step(8'h0c);
      skip_active <= 1'b0;
      motion_cmd <= `SPRC_CMD_IDLE;
      accel_quarter <= 2'h1;
      accel_half <= 2'h1;
      $display("test step_size done");
      repeat (10) @(posedge clock);
      motion_cmd <= `SPRC_CMD_SCAN;
      repeat (800) @(posedge clock);
      pulse(0);
      wait_sig(2, 1'b0, 1000);
      check_val("stored lines", 8'h03, 8'(n));
      check_val("paused", 8'h01, 8'(paused));
      check_val("forward", 8'h01, 8'(motor_forward));
      pulse(1);
      wait_sig(0, 1'b0, 500);
      check_val("paused", 8'h00, 8'(paused));
      check_val("store", 8'h00, 8'(line_store_en));
      wait_sig(2, 1'b1, 1000);
      check_val("discarded lines", 8'h02, 8'(n));
      $display("test plain_pause done");
      reverse_steps <= 8'h02;
      full_step_mode <= 1'b1;
      repeat (800) @(posedge clock);
      pulse(0);
      wait_sig(2, 1'b0, 1000);
      check_val("stored lines", 8'h01, 8'(n));
      wait_sig(1, 1'b0, 3000);
      check_val("forward", 8'h00, 8'(motor_forward));
      wait_sig(0, 1'b1, 3000);
      check_val("paused", 8'h01, 8'(paused));
      repeat (16) @(posedge clock);
      check_val("hold code", {2'h0, `SPRC_DAC_HOLD, `SPRC_DAC_HOLD}, {2'h0, dac_a, dac_b});
      repeat (100) @(posedge clock);
      check_val("held phases", 8'h00, {phase_a, phase_a_n, phase_b, phase_b_n, 1'b0, dac_a});
      pulse(1);
      wait_sig(0, 1'b0, 1000);
      check_val("paused", 8'h00, 8'(paused));
      wait_sig(1, 1'b1, 1000);
      check_val("forward", 8'h01, 8'(motor_forward));
      repeat (800) @(posedge clock);
      check_val("run code", {5'h00, `SPRC_DAC_RUN}, {5'h00, dac_a});
      $display("test reverse_pause done");
      report_and_stop;
   end
   // A hang ends the run as a mismatch.
   initial begin
      #400000;
      miscompares = miscompares + 1;
      report_and_stop;
   end
endmodule

// [sprc_winding_model.sv]
// Behavioural model of the driver transistors, windings and sense comparators.
`timescale 1ns/1ns
module sprc_winding_model (
   input wire clock,
   input wire phase_a,
   input wire phase_a_n,
   input wire phase_b,
   input wire phase_b_n,
   input wire [2:0] dac_a,
   input wire [2:0] dac_b,
   output reg sense_a_high,
   output reg sense_b_high
);
   integer cur_a = 0;
   integer cur_b = 0;
   initial begin
      sense_a_high = 1'b0;
      sense_b_high = 1'b0;
   end
   // Current ramps while driven and decays otherwise, so the PWM loop has something to regulate.
   always @(posedge clock) begin
      cur_a <= (phase_a | phase_a_n) ? cur_a + 3 : cur_a - cur_a / 8;
      cur_b <= (phase_b | phase_b_n) ? cur_b + 3 : cur_b - cur_b / 8;
      sense_a_high <= cur_a > 16 * dac_a;
      sense_b_high <= cur_b > 16 * dac_b;
   end
endmodule
